// [shared/pwsc_defines.svh]
/*
  Constants of the program wait, halt and coordinate store block: opcodes,
  condition codes, tick timing, register offsets and bit positions.
  Assumes inclusion by bare name from any file that needs them.
*/
`ifndef PWSC_DEFINES_SVH
`define PWSC_DEFINES_SVH

`define OP_WAIT 8'h1b
`define OP_HALT 8'h1c
`define OP_SET_COORD 8'h1e

`define WAIT_TICKS 8'h00
`define WAIT_TARGET 8'h01
`define WAIT_HOME_SWITCH 8'h02
`define WAIT_END_SWITCH 8'h03
`define WAIT_HOMING_DONE 8'h04

`define TICKS_FROM_ACC 32'hffffffff
`define MOTOR_ALL 8'hff
`define SLOT_MAX 8'h14
`define SLOT_COUNT 21
`define JC_TIMEOUT 8'h08

`define CLK_HZ 20000000
`define TICK_MS 10
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_TICKS 8'h08
`define REG_LIMIT 8'h0c

`define CTRL_PERSIST 0
`define CTRL_RESTORE 1
`define CTRL_RUN 2
`define CTRL_RESET 32'h00000000

`endif

// [shared/pwsc_pkg.sv]
/*
  Types shared by the wait, halt and coordinate store block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pwsc_pkg;

  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_WAIT = 4'h2,
    SEQ_NVWR = 4'h4,
    SEQ_NVRD = 4'h8
  } seq_state_type;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] kind;
    logic [7:0] motor;
    logic [31:0] value;
  } instr_type;

endpackage

// [shared/tick_if.sv]
/*
  Carrier between the instruction sequencer and its tick generator.
  Assumes both ends run on the same clock.
*/
interface tick_if;
  logic restart;
  logic tick;

  modport gen (
    input restart,
    output tick
  );

  modport user (
    output restart,
    input tick
  );
endinterface

// [core/tick_gen.sv]
/*
  Free running tick generator that a restart realigns.
  Assumes a single clock and an asynchronous active low reset.
*/
module tick_gen #(
  parameter int TICK_CYCLES = 200000
) (
  input wire logic core_clk,
  input wire logic resetn,
  tick_if.gen tk
);

  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } tick_state_type;

  tick_state_type state_ff;
  tick_state_type nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.tick = 1'b0;
    if (tk.restart) begin
      nxt_state.count = '0;
    end else if (state_ff.count == 32'(TICK_CYCLES - 1)) begin
      nxt_state.count = '0;
      nxt_state.tick = 1'b1;
    end else begin
      nxt_state.count = state_ff.count + 32'h00000001;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign tk.tick = state_ff.tick;

endmodule

// [core/program_wait_stop_coordinate_store.sv]
/*
  Sequencer for the event wait, program halt and set coordinate
  instructions of a stored-program motion interpreter, with the
  coordinate array and its copy to non-volatile memory.
  Assumes the interpreter presents one decoded instruction at a time,
  supplies the accumulator and motion status, and owns the program counter.
*/
// Summary of operation
// - Hold program counter until wait ends
// - Wait kinds: ticks, target, home, end, homing
// - Tick wait ignores motor, counts value ticks
// - Other waits: value is timeout, zero none
// - Target condition from selected motor
// - Home switch condition from selected motor
// - Either end switch of selected motor
// - Homing done of selected motor
// - Value minus one takes accumulator
// - Timeout sets sticky flag until clear
// - Ticks every 10 milliseconds
// - Halt instruction stops program, fields ignored
// - Twenty-one signed slots per motor
// - Set coordinate stores value in slot
// - Persistence setting, default RAM only
// - Slot zero never persisted or restored
// - Motor all, slot zero: copy all
// - Motor all, slot n: copy one
// - Jump code eight tests timeout flag
`include "pwsc_defines.svh"
module program_wait_stop_coordinate_store #(
  parameter int NUM_MOTORS = 1,
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  input wire logic instrValid,
  input wire pwsc_pkg::instr_type instr,
  output logic instrReady,
  input wire logic [31:0] accumulator,
  input wire logic clearError,
  output logic pcHold,
  output logic pcAdvance,
  output logic programRunning,
  output logic timeoutErrorFlag,
  input wire logic jcValid,
  input wire logic [7:0] jcCondition,
  output logic jcTaken,
  input wire logic [NUM_MOTORS-1:0] targetReached,
  input wire logic [NUM_MOTORS-1:0] homeSwitch,
  input wire logic [NUM_MOTORS-1:0] endSwitchLeft,
  input wire logic [NUM_MOTORS-1:0] endSwitchRight,
  input wire logic [NUM_MOTORS-1:0] homingDone,
  input wire logic [7:0] coordRdMotor,
  input wire logic [7:0] coordRdSlot,
  output logic [31:0] coordRdData,
  output logic nvWrValid,
  input wire logic nvWrReady,
  output logic nvRdReq,
  input wire logic nvRdAck,
  input wire logic [31:0] nvRdData,
  output logic [$clog2(NUM_MOTORS * `SLOT_COUNT + 1)-1:0] nvAddr,
  output logic [31:0] nvWrData
);
  import pwsc_pkg::*;

  localparam int SLOTS = `SLOT_COUNT;
  localparam int MW = (NUM_MOTORS > 1) ? $clog2(NUM_MOTORS) : 1;
  localparam int ADDRW = $clog2(NUM_MOTORS * SLOTS + 1);

  typedef struct packed {
    seq_state_type state;
    logic ready;
    logic [31:0] limit;
    logic [31:0] tickCnt;
    logic [7:0] waitKind;
    logic [7:0] waitMotor;
    logic timed;
    logic timeoutFlag;
    logic running;
    logic persist;
    logic restorePend;
    logic pcHold;
    logic pcAdvance;
    logic tickRestart;
    logic jumpTaken;
    logic nvWrValid;
    logic nvRdReq;
    logic nvAll;
    logic nvOne;
    logic [4:0] nvSlot;
    logic [MW-1:0] nvMotor;
    logic [ADDRW-1:0] nvAddr;
    logic [31:0] nvWrData;
    logic [31:0] rdData;
    logic [31:0] coordRdData;
    logic [NUM_MOTORS-1:0][SLOTS-1:0][31:0] coord;
  } core_state_type;

  core_state_type state_ff;
  core_state_type nxt_state;

  tick_if tk ();

  tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick_gen (
    .core_clk(core_clk),
    .resetn(resetn),
    .tk(tk)
  );

  assign tk.restart = state_ff.tickRestart;

  // A motor number outside the axis count selects nothing, so the wait never
  // completes on its condition and only a timeout can end it.
  function automatic logic motorBit(input logic [NUM_MOTORS-1:0] vec, input logic [7:0] motor);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_MOTORS; i++) begin
      if (motor == 8'(i)) begin
        hit = vec[i];
      end
    end
    return hit;
  endfunction

  function automatic logic [ADDRW-1:0] nvIndex(input logic [MW-1:0] motor, input logic [4:0] slot);
    return ADDRW'(int'(motor) * SLOTS + int'(slot));
  endfunction

  function automatic logic motorValid(input logic [7:0] motor);
    return int'(motor) < NUM_MOTORS;
  endfunction

  logic condMet;
  logic [31:0] tickNow;
  logic [31:0] issueLimit;
  logic restoreReq;
  logic nvLast;
  logic [4:0] nvNextSlot;
  logic [MW-1:0] nvNextMotor;
  logic waitDone;
  logic waitTimeout;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.pcAdvance = 1'b0;
    nxt_state.tickRestart = 1'b0;
    nxt_state.jumpTaken = 1'b0;
    nxt_state.rdData = '0;
    restoreReq = 1'b0;
    waitDone = 1'b0;
    waitTimeout = 1'b0;

    // Register slave: reads answer in the following cycle, unmapped read zero.
    if (regRdStb) begin
      if (regAddr == `REG_CTRL) begin
        nxt_state.rdData = {29'h0, state_ff.running, 1'b0, state_ff.persist};
      end else if (regAddr == `REG_STATUS) begin
        nxt_state.rdData = {24'h0, state_ff.state, state_ff.restorePend,
                            state_ff.timeoutFlag, state_ff.running, state_ff.pcHold};
      end else if (regAddr == `REG_TICKS) begin
        nxt_state.rdData = state_ff.tickCnt;
      end else if (regAddr == `REG_LIMIT) begin
        nxt_state.rdData = state_ff.limit;
      end
    end
    if (regWrStb && regAddr == `REG_CTRL) begin
      nxt_state.persist = regWrData[`CTRL_PERSIST];
      restoreReq = regWrData[`CTRL_RESTORE];
      if (regWrData[`CTRL_RUN]) begin
        nxt_state.running = 1'b1;
      end
    end
    // A restore asked for without persistence has nothing to bring back.
    if (restoreReq && state_ff.persist) begin
      nxt_state.restorePend = 1'b1;
    end

    if (jcValid) begin
      nxt_state.jumpTaken = (jcCondition == `JC_TIMEOUT) && state_ff.timeoutFlag;
    end

    if (motorValid(coordRdMotor) && coordRdSlot <= `SLOT_MAX) begin
      nxt_state.coordRdData = state_ff.coord[MW'(coordRdMotor)][5'(coordRdSlot)];
    end else begin
      nxt_state.coordRdData = '0;
    end

    // Condition selection by wait kind.
    if (state_ff.waitKind == `WAIT_TARGET) begin
      condMet = motorBit(targetReached, state_ff.waitMotor);
    end else if (state_ff.waitKind == `WAIT_HOME_SWITCH) begin
      condMet = motorBit(homeSwitch, state_ff.waitMotor);
    end else if (state_ff.waitKind == `WAIT_END_SWITCH) begin
      condMet = motorBit(endSwitchLeft | endSwitchRight, state_ff.waitMotor);
    end else if (state_ff.waitKind == `WAIT_HOMING_DONE) begin
      condMet = motorBit(homingDone, state_ff.waitMotor);
    end else begin
      condMet = 1'b0;
    end
    // A tick already in flight when the wait starts belongs to the old phase, so it is skipped.
    tickNow = (tk.tick && !state_ff.tickRestart) ? state_ff.tickCnt + 32'h00000001
                                                 : state_ff.tickCnt;
    issueLimit = (instr.value == `TICKS_FROM_ACC) ? accumulator : instr.value;

    // Non-volatile walker: across slots 1 to 20 for a full copy, then motors.
    nvLast = state_ff.nvOne ||
             ((!state_ff.nvAll || state_ff.nvSlot == 5'(`SLOT_MAX)) &&
              int'(state_ff.nvMotor) == NUM_MOTORS - 1);
    if (state_ff.nvAll && state_ff.nvSlot != 5'(`SLOT_MAX)) begin
      nvNextSlot = state_ff.nvSlot + 5'h01;
      nvNextMotor = state_ff.nvMotor;
    end else begin
      nvNextSlot = state_ff.nvAll ? 5'h01 : state_ff.nvSlot;
      nvNextMotor = state_ff.nvMotor + MW'(1);
    end

    case (state_ff.state)
      SEQ_IDLE: begin
        if (instrValid && instr.opcode == `OP_WAIT) begin
          nxt_state.waitKind = instr.kind;
          nxt_state.waitMotor = instr.motor;
          nxt_state.limit = issueLimit;
          nxt_state.timed = (issueLimit != 32'h00000000);
          nxt_state.tickCnt = '0;
          nxt_state.tickRestart = 1'b1;
          if (instr.kind > `WAIT_HOMING_DONE) begin
            // Unknown kinds complete at once rather than lock the program.
            nxt_state.pcAdvance = 1'b1;
          end else begin
            nxt_state.pcHold = 1'b1;
            nxt_state.state = SEQ_WAIT;
          end
        end else if (instrValid && instr.opcode == `OP_HALT) begin
          nxt_state.running = 1'b0;
          nxt_state.pcAdvance = 1'b1;
        end else if (instrValid && instr.opcode == `OP_SET_COORD) begin
          nxt_state.pcAdvance = 1'b1;
          if (instr.motor == `MOTOR_ALL && instr.kind <= `SLOT_MAX) begin
            nxt_state.nvAll = (instr.kind == 8'h00);
            nxt_state.nvOne = 1'b0;
            nxt_state.nvSlot = (instr.kind == 8'h00) ? 5'h01 : 5'(instr.kind);
            nxt_state.nvMotor = '0;
            nxt_state.nvAddr = nvIndex('0, nxt_state.nvSlot);
            nxt_state.nvWrData = state_ff.coord[0][nxt_state.nvSlot];
            nxt_state.nvWrValid = 1'b1;
            nxt_state.state = SEQ_NVWR;
          end else if (motorValid(instr.motor) && instr.kind <= `SLOT_MAX) begin
            nxt_state.coord[MW'(instr.motor)][5'(instr.kind)] = instr.value;
            if (state_ff.persist && instr.kind != 8'h00) begin
              nxt_state.nvAll = 1'b0;
              nxt_state.nvOne = 1'b1;
              nxt_state.nvSlot = 5'(instr.kind);
              nxt_state.nvMotor = MW'(instr.motor);
              nxt_state.nvAddr = nvIndex(MW'(instr.motor), 5'(instr.kind));
              nxt_state.nvWrData = instr.value;
              nxt_state.nvWrValid = 1'b1;
              nxt_state.state = SEQ_NVWR;
            end
          end
        end else if (state_ff.restorePend) begin
          nxt_state.restorePend = 1'b0;
          nxt_state.nvAll = 1'b1;
          nxt_state.nvOne = 1'b0;
          nxt_state.nvSlot = 5'h01;
          nxt_state.nvMotor = '0;
          nxt_state.nvAddr = nvIndex('0, 5'h01);
          nxt_state.nvRdReq = 1'b1;
          nxt_state.state = SEQ_NVRD;
        end
      end
      SEQ_WAIT: begin
        nxt_state.tickCnt = tickNow;
        if (state_ff.waitKind == `WAIT_TICKS) begin
          waitDone = (tickNow >= state_ff.limit);
        end else if (condMet) begin
          waitDone = 1'b1;
        end else if (state_ff.timed && tickNow >= state_ff.limit) begin
          waitDone = 1'b1;
          waitTimeout = 1'b1;
        end
        if (waitDone) begin
          nxt_state.pcHold = 1'b0;
          nxt_state.pcAdvance = 1'b1;
          nxt_state.state = SEQ_IDLE;
        end
      end
      SEQ_NVWR: begin
        if (nvWrReady) begin
          if (nvLast) begin
            nxt_state.nvWrValid = 1'b0;
            nxt_state.state = SEQ_IDLE;
          end else begin
            nxt_state.nvSlot = nvNextSlot;
            nxt_state.nvMotor = nvNextMotor;
            nxt_state.nvAddr = nvIndex(nvNextMotor, nvNextSlot);
            nxt_state.nvWrData = state_ff.coord[nvNextMotor][nvNextSlot];
          end
        end
      end
      SEQ_NVRD: begin
        if (nvRdAck) begin
          nxt_state.coord[state_ff.nvMotor][state_ff.nvSlot] = nvRdData;
          if (nvLast) begin
            nxt_state.nvRdReq = 1'b0;
            nxt_state.state = SEQ_IDLE;
          end else begin
            nxt_state.nvSlot = nvNextSlot;
            nxt_state.nvMotor = nvNextMotor;
            nxt_state.nvAddr = nvIndex(nvNextMotor, nvNextSlot);
          end
        end
      end
      default: begin
        nxt_state.state = SEQ_IDLE;
      end
    endcase

    // The clear-error instruction loses against a timeout in the same cycle.
    if (clearError) begin
      nxt_state.timeoutFlag = 1'b0;
    end
    if (waitTimeout) begin
      nxt_state.timeoutFlag = 1'b1;
    end
    nxt_state.ready = (nxt_state.state == SEQ_IDLE);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= '0;
      state_ff.state <= SEQ_IDLE;
      state_ff.ready <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign regRdData = state_ff.rdData;
  assign instrReady = state_ff.ready;
  assign pcHold = state_ff.pcHold;
  assign pcAdvance = state_ff.pcAdvance;
  assign programRunning = state_ff.running;
  assign timeoutErrorFlag = state_ff.timeoutFlag;
  assign jcTaken = state_ff.jumpTaken;
  assign coordRdData = state_ff.coordRdData;
  assign nvWrValid = state_ff.nvWrValid;
  assign nvRdReq = state_ff.nvRdReq;
  assign nvAddr = state_ff.nvAddr;
  assign nvWrData = state_ff.nvWrData;

endmodule

// [bench/pwsc_assertions.sv]
/* Checker for the wait, halt and coordinate store block.
   Assumes binding to the top module with NUM_MOTORS of 1 (five bit NV address). */
module pwsc_assertions (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic instrValid,
  input wire pwsc_pkg::instr_type instr,
  input wire logic instrReady,
  input wire logic pcHold,
  input wire logic pcAdvance,
  input wire logic programRunning,
  input wire logic timeoutErrorFlag,
  input wire logic clearError,
  input wire logic jcValid,
  input wire logic [7:0] jcCondition,
  input wire logic jcTaken,
  input wire logic nvWrValid,
  input wire logic nvWrReady,
  input wire logic [4:0] nvAddr,
  input wire logic [31:0] nvWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  import pwsc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic take;
  assign take = instrValid && instrReady;
  a_wait_holds: assert property (
    take && instr.opcode == 8'h1b && instr.kind <= 8'h04 |=> pcHold && !instrReady)
    else $error("wait did not hold the counter");
  a_hold_blocks: assert property (pcHold |-> !instrReady)
    else $error("instruction accepted during a wait");
  a_advance_ends: assert property (pcAdvance |-> !pcHold)
    else $error("advance while still holding");
  a_halt_stops: assert property (
    take && instr.opcode == 8'h1c |=> pcAdvance && !programRunning)
    else $error("halt did not stop the program");
  a_store_advance: assert property (take && instr.opcode == 8'h1e |=> pcAdvance)
    else $error("set coordinate did not advance");
  a_flag_sticky: assert property ($fell(timeoutErrorFlag) |-> $past(clearError))
    else $error("timeout flag dropped without clear");
  a_timeout_release: assert property ($rose(timeoutErrorFlag) |-> pcAdvance)
    else $error("timeout did not release the counter");
  a_jump_timeout: assert property (
    jcValid |=> jcTaken == ($past(jcCondition) == 8'h08 && $past(timeoutErrorFlag)))
    else $error("timeout jump decision wrong");
  a_nv_stable: assert property (
    nvWrValid && !nvWrReady |=> nvWrValid && $stable(nvAddr) && $stable(nvWrData))
    else $error("NV write dropped or changed before ready");
endmodule

bind program_wait_stop_coordinate_store pwsc_assertions chk_u (.*);

// [bench/nv_mem_model.sv]
/* Behavioural non-volatile word store at the far side of the NV port.
   Assumes one clock; a slow request adds three wait cycles before the answer. */
module nv_mem_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic nvWrValid,
  input wire logic nvRdReq,
  input wire logic [4:0] nvAddr,
  input wire logic [31:0] nvWrData,
  input wire logic slow,
  output logic nvWrReady,
  output logic nvRdAck,
  output logic [31:0] nvRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:31];
  logic [4:0] wrLog [$];
  int cnt;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      nvWrReady <= 1'h0;
      nvRdAck <= 1'h0;
      nvRdData <= 32'h0;
      cnt <= 0;
    end else begin
      nvWrReady <= 1'h0;
      nvRdAck <= 1'h0;
      // Read data is only good with the ack, so it churns at all other times.
      nvRdData <= ~nvRdData;
      if (nvWrValid && nvWrReady) begin
        mem[nvAddr] <= nvWrData;
        wrLog.push_back(nvAddr);
      end
      if ((nvWrValid || nvRdReq) && !nvWrReady && !nvRdAck) begin
        if (slow && cnt < 3) begin
          cnt <= cnt + 1;
        end else begin
          cnt <= 0;
          nvWrReady <= nvWrValid;
          nvRdAck <= nvRdReq;
          nvRdData <= mem[nvAddr];
        end
      end
    end
  end
endmodule

// [bench/test_program_wait_stop_coordinate_store.sv]
/* Self-checking bench for the wait, halt and coordinate store block.
   Assumes the NV model beside the design and a short tick period. */
`include "pwsc_defines.svh"
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin nFail++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module test_program_wait_stop_coordinate_store;
  timeunit 1ns;
  timeprecision 1ps;
  import pwsc_pkg::*;
  localparam int TC = 8;
  logic core_clk = 0, resetn = 0, regWrStb = 0, regRdStb = 0, instrValid = 0;
  logic clearError = 0, jcValid = 0, slow = 0, targetReached = 0, homeSwitch = 0;
  logic endSwitchLeft = 0, endSwitchRight = 0, homingDone = 0;
  logic [7:0] regAddr = 8'h0, jcCondition = 8'h0, coordRdMotor = 8'h0, coordRdSlot = 8'h0;
  logic [31:0] regWrData = 32'h0, accumulator = 32'h0, regRdData, coordRdData, nvRdData;
  logic [31:0] nvWrData, r;
  logic [4:0] nvAddr, a;
  instr_type instr = '0;
  logic instrReady, pcHold, pcAdvance, programRunning, timeoutErrorFlag, jcTaken;
  logic nvWrValid, nvWrReady, nvRdReq, nvRdAck;
  int nFail = 0, cmpCount = 0, n, d, v, exp[22];
  program_wait_stop_coordinate_store #(.NUM_MOTORS(1), .TICK_CYCLES(TC)) dut_u (.*);
  nv_mem_model nv_u (.*);
  always #25 core_clk = ~core_clk;
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(20000 * 50);
    nFail++;
    conclude();
  end
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge core_clk);
    regAddr <= ad;
    regWrData <= dt;
    regWrStb <= 1'h1;
    @(posedge core_clk);
    regWrStb <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge core_clk);
    regAddr <= ad;
    regRdStb <= 1'h1;
    @(posedge core_clk);
    regRdStb <= 1'h0;
    #1 r = regRdData;
  endtask
  task automatic crd(input logic [7:0] s);
    @(posedge core_clk);
    coordRdSlot <= s;
    @(posedge core_clk);
    #1 r = coordRdData;
  endtask
  task automatic jc(input logic [7:0] c);
    @(posedge core_clk);
    jcValid <= 1'h1;
    jcCondition <= c;
    @(posedge core_clk);
    jcValid <= 1'h0;
    #1 r = {31'h0, jcTaken};
  endtask
  task automatic idle;
    for (int i = 0; i < 900 && instrReady !== 1'h1; i++) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  // Counts cycles from the accepting edge until the advance pulse is seen.
  task automatic run(input logic [7:0] op, k, m, input logic [31:0] val);
    idle();
    @(posedge core_clk);
    instr <= '{op, k, m, val};
    instrValid <= 1'h1;
    @(posedge core_clk);
    instrValid <= 1'h0;
    #1 n = 1;
    while (pcAdvance !== 1'h1 && n < 900) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask
  task automatic nvCheck(input int s);
    a = nv_u.wrLog.pop_front();
    `CHK("nv addr", 5'(s), a)
    `CHK("nv data", exp[s], nv_u.mem[s])
  endtask
  function automatic logic [4:0] mask(int k, bit alt);
    if (k == 4) return 5'h10;
    if (k == 3 && alt) return 5'h08;
    return 5'h01 << (k - 1);
  endfunction
  initial begin
    void'($urandom(49791));
    repeat (3) @(posedge core_clk);
    resetn <= 1'h1;
    rd(`REG_CTRL);
    `CHK("ctrl reset", 32'h0, r)
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 0 : $urandom % 5;
      run(`OP_WAIT, `WAIT_TICKS, 8'($urandom), v);
      `CHK("tick wait", (v == 0) ? 2 : v * TC + 3, n)
    end
    accumulator <= 32'h3;
    run(`OP_WAIT, `WAIT_TICKS, 8'h0, `TICKS_FROM_ACC);
    `CHK("acc wait", 3 * TC + 3, n)
    rd(`REG_LIMIT);
    `CHK("acc limit", 32'h3, r)
    run(`OP_WAIT, 8'(5 + $urandom % 8), 8'h0, 32'h5);
    `CHK("bad kind", 1, n)
    for (int k = 1; k <= 4; k++) begin
      d = 2 + $urandom % 20;
      idle();
      fork
        run(`OP_WAIT, 8'(k), 8'h0, 32'h0);
        begin
          repeat (d + 1) @(posedge core_clk);
          {homingDone, endSwitchRight, endSwitchLeft, homeSwitch, targetReached} <=
            mask(k, $urandom % 2);
        end
      join
      `CHK("cond wait", d + 1, n)
      {homingDone, endSwitchRight, endSwitchLeft, homeSwitch, targetReached} <= 5'h0;
    end
    `CHK("no timeout", 1'h0, timeoutErrorFlag)
    run(`OP_WAIT, 8'(1 + $urandom % 4), 8'h0, 32'h2);
    `CHK("timeout", 2 * TC + 3, n)
    `CHK("flag set", 1'h1, timeoutErrorFlag)
    accumulator <= 32'h1;
    run(`OP_WAIT, `WAIT_TARGET, 8'h0, `TICKS_FROM_ACC);
    `CHK("acc timeout", TC + 3, n)
    jc(8'h08);
    `CHK("jump on flag", 32'h1, r)
    jc(8'h05);
    `CHK("other code", 32'h0, r)
    @(posedge core_clk);
    clearError <= 1'h1;
    @(posedge core_clk);
    clearError <= 1'h0;
    #1 `CHK("flag clear", 1'h0, timeoutErrorFlag)
    jc(8'h08);
    `CHK("no jump", 32'h0, r)
    wr(`REG_CTRL, 32'h4);
    #1 `CHK("running", 1'h1, programRunning)
    run(`OP_HALT, 8'($urandom), 8'($urandom), $urandom);
    `CHK("halt", 1'h0, programRunning)
    exp[21] = 0;
    for (int s = 0; s <= 21; s++) begin
      exp[s] = (s < 21) ? $urandom : 0;
      run(`OP_SET_COORD, 8'(s), 8'h0, (s < 21) ? exp[s] : $urandom);
    end
    run(`OP_SET_COORD, 8'h2, 8'h1, $urandom);
    for (int s = 0; s <= 21; s++) begin
      crd(8'(s));
      `CHK("coord", exp[s], r)
    end
    `CHK("ram only", 0, nv_u.wrLog.size())
    wr(`REG_CTRL, 32'h1);
    slow <= 1'($urandom);
    exp[3] = $urandom;
    run(`OP_SET_COORD, 8'h3, 8'h0, exp[3]);
    exp[0] = $urandom;
    run(`OP_SET_COORD, 8'h0, 8'h0, exp[0]);
    idle();
    nvCheck(3);
    `CHK("slot zero", 0, nv_u.wrLog.size())
    run(`OP_SET_COORD, 8'h5, `MOTOR_ALL, 32'h0);
    idle();
    nvCheck(5);
    slow <= 1'h1;
    run(`OP_SET_COORD, 8'h0, `MOTOR_ALL, 32'h0);
    idle();
    for (int s = 1; s <= 20; s++) nvCheck(s);
    `CHK("copy count", 0, nv_u.wrLog.size())
    wr(`REG_CTRL, 32'h0);
    run(`OP_SET_COORD, 8'h7, 8'h0, ~exp[7]);
    exp[0] = $urandom;
    run(`OP_SET_COORD, 8'h0, 8'h0, exp[0]);
    wr(`REG_CTRL, 32'h1);
    wr(`REG_CTRL, 32'h3);
    r = 32'h0;
    for (int i = 0; i < 300 && !(r[7:4] === 4'h1 && r[3] === 1'h0); i++) rd(`REG_STATUS);
    `CHK("status idle", 32'h10, r)
    crd(8'h7);
    `CHK("restored", exp[7], r)
    crd(8'h0);
    `CHK("slot zero kept", exp[0], r)
    conclude();
  end
endmodule
